//--- rtl/sst_pkg.sv
// Constants, field layouts, opcodes and carrier types of the stepper status and command block
// Functional notes
// - Any enabled active alarm condition pulls the alarm pin low.
// - Mask bits: 0 overcurrent, 1 heat stop, 2 heat warning, 3 undervoltage, 6 command.
// - Pin mode 0, codes 0-3: internal 16 MHz; mode 1 outputs 2/4/8/16 MHz.
// - Pin mode 0, codes 4-7: crystal across both pins, 8/16/24/32 MHz.
// - Pin mode 1, codes 4-7: crystal driver off, input clock, output inverted.
// - Contact stop select 0 halts at once on closure; 1 leaves contact to user.
// - Overcurrent shutdown enable chooses bridge turn-off; overcurrent flag goes low regardless.
// - Edge rate code 00/01/10/11 gives 320/75/110/270 volts per microsecond.
// - Torque source 0 uses internal setpoints, 1 uses the analog input conversion.
// - Chop period code 0,1 gives 4 us, then 4 us per code step.
// - Setup write while running and any flag word write are ignored, refused flag set.
// - Floating flag shows high impedance; motion and halts leave it unless errors force it; the pulse mode command does not leave it.
// - Low supply flag low on undervoltage or reset; heat, overcurrent low; command flags high.
// - Contact level is high when closed; contact event on input falling edge.
// - Fault, command and contact event flags stay latched until the flag read command.
// - Busy bit equals busy pin; low while motion commands execute, high after.
// - External pulse flag in step-clock mode; direction 1 forward; phase encodings.
// - Opcodes 000a_aaaa write, 001a_aaaa read a setting; zero byte is no operation.
// - Motion opcode patterns for rate, pulse mode, steps, seeks, origin and marker.
// - Contact seek ramps to halt on closure; back-off at min speed halts on opening.
// - Halt, float, position clear, reinit and flag read opcodes; two reserved codes.
// - Bytes matching no opcode are ignored and set the unknown command flag.
package sst_pkg;

  // Setting addresses of the three registers held here
  localparam logic [4:0] SST_ADDR_ALARM = 5'h17;
  localparam logic [4:0] SST_ADDR_SETUP = 5'h18;
  localparam logic [4:0] SST_ADDR_FLAGS = 5'h19;
  localparam logic [4:0] SST_ADDR_MIN   = 5'h01;
  localparam logic [4:0] SST_ADDR_MAX   = 5'h1b;

  // Reset values
  localparam logic [7:0]  SST_ALARM_RST = 8'hff;
  localparam logic [15:0] SST_SETUP_RST = 16'h0000;

  // Alarm mask layout
  localparam int SST_AL_OC  = 0;
  localparam int SST_AL_HSD = 1;
  localparam int SST_AL_HWR = 2;
  localparam int SST_AL_UV  = 3;
  localparam int SST_AL_CMD = 6;
  localparam logic [7:0] SST_AL_USED = 8'h4f;

  // Setup word layout
  localparam int SST_SU_CLK_LSB   = 0;
  localparam int SST_SU_CLK_MSB   = 2;
  localparam int SST_SU_PIN_MODE  = 3;
  localparam int SST_SU_CSTOP     = 4;
  localparam int SST_SU_TORQUE    = 5;
  localparam int SST_SU_OVERCURRENT_SHUTDOWN_EN     = 7;
  localparam int SST_SU_EDGE_LSB  = 8;
  localparam int SST_SU_EDGE_MSB  = 9;
  localparam int SST_SU_CHOP_LSB  = 10;
  localparam int SST_SU_CHOP_MSB  = 14;
  localparam int SST_SU_PRED      = 15;

  // Flag word layout
  localparam int SST_FW_HIZ   = 0;
  localparam int SST_FW_BUSY  = 1;
  localparam int SST_FW_CLVL  = 2;
  localparam int SST_FW_CEVT  = 3;
  localparam int SST_FW_DIR   = 4;
  localparam int SST_FW_PH_LSB = 5;
  localparam int SST_FW_PH_MSB = 6;
  localparam int SST_FW_REF   = 7;
  localparam int SST_FW_UNK   = 8;
  localparam int SST_FW_UV_N  = 9;
  localparam int SST_FW_HWR_N = 10;
  localparam int SST_FW_HSD_N = 11;
  localparam int SST_FW_OC_N  = 12;
  localparam int SST_FW_EXTP  = 15;

  // Opcodes and the masks that strip their argument bits
  localparam logic [7:0] SST_MASK_ALL = 8'hff;
  localparam logic [7:0] SST_MASK_D   = 8'hfe;
  localparam logic [7:0] SST_MASK_AD  = 8'hf6;
  localparam logic [2:0] SST_OP_SET   = 3'h0;
  localparam logic [2:0] SST_OP_GET   = 3'h1;
  localparam logic [7:0] SST_OP_NOP   = 8'h00;
  localparam logic [7:0] SST_OP_RATE  = 8'h50;
  localparam logic [7:0] SST_OP_EXTP  = 8'h58;
  localparam logic [7:0] SST_OP_STEP  = 8'h40;
  localparam logic [7:0] SST_OP_SEEK  = 8'h60;
  localparam logic [7:0] SST_OP_SEEKD = 8'h68;
  localparam logic [7:0] SST_OP_HOME  = 8'h70;
  localparam logic [7:0] SST_OP_MARK  = 8'h78;
  localparam logic [7:0] SST_OP_SCON  = 8'h82;
  localparam logic [7:0] SST_OP_BACK  = 8'h92;
  localparam logic [7:0] SST_OP_RHALT = 8'hb0;
  localparam logic [7:0] SST_OP_IHALT = 8'hb8;
  localparam logic [7:0] SST_OP_FRAMP = 8'ha0;
  localparam logic [7:0] SST_OP_FNOW  = 8'ha8;
  localparam logic [7:0] SST_OP_PCLR  = 8'hd8;
  localparam logic [7:0] SST_OP_INIT  = 8'hc0;
  localparam logic [7:0] SST_OP_FREAD = 8'hd0;
  localparam logic [7:0] SST_OP_RSV0  = 8'heb;
  localparam logic [7:0] SST_OP_RSV1  = 8'hf8;
  localparam int SST_OP_ACT = 3;

  // Output slew rates in volts per microsecond
  localparam logic [8:0] SST_SLEW_0 = 9'h140;
  localparam logic [8:0] SST_SLEW_1 = 9'h04b;
  localparam logic [8:0] SST_SLEW_2 = 9'h06e;
  localparam logic [8:0] SST_SLEW_3 = 9'h10e;

  // Chop period in microseconds
  localparam logic [6:0] SST_CHOP_STEP_US = 7'h04;
  localparam logic [4:0] SST_CHOP_MIN_CODE = 5'h02;

  // Pin synchroniser lanes
  localparam int SST_SYNC_W = 8;

  typedef struct packed {
    logic rate;
    logic ext_pulse;
    logic rel_step;
    logic seek;
    logic seek_dir;
    logic origin;
    logic marker;
    logic seek_contact;
    logic back_off;
    logic ramp_halt;
    logic imm_halt;
    logic float_ramp;
    logic float_now;
    logic pos_clear;
    logic reinit;
    logic action;
    logic dir;
  } sst_motion_t;

  typedef struct packed {
    logic       int_osc;
    logic       xtal_drive;
    logic       ext_in;
    logic       out_en;
    logic [1:0] out_sel;
    logic [1:0] freq_sel;
  } sst_clock_t;

endpackage

//--- rtl/sst_sync2.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module sst_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;
endmodule
`default_nettype wire

//--- rtl/sst_stepper_status_command_decode.sv
// Command decoder, setup, alarm mask and latched flag word of the stepper driver
`timescale 1ns/1ps
`default_nettype none
module sst_stepper_status_command_decode (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_cmd_valid,
  input  wire logic [7:0]         i_cmd_byte,
  input  wire logic               i_set_wr,
  input  wire logic [4:0]         i_set_addr,
  input  wire logic [15:0]        i_set_data,
  input  wire logic               i_motor_running,
  input  wire logic [1:0]         i_motion_phase,
  input  wire logic               i_overcurrent,
  input  wire logic               i_heat_shutdown,
  input  wire logic               i_heat_warning,
  input  wire logic               i_undervoltage,
  input  wire logic               i_limit_contact_input,
  input  wire logic               i_busy_pin,
  input  wire logic               i_external_pulse_input,
  input  wire logic               i_clock_in_pin,
  output sst_pkg::sst_motion_t    o_motion_req,
  output logic                    o_read_valid,
  output logic [15:0]             o_read_data,
  output logic [15:0]             o_flag_word,
  output logic                    o_alarm_pin_o,
  output logic                    o_alarm_pin_oe,
  output sst_pkg::sst_clock_t     o_clock_cfg,
  output logic                    o_clock_out_pin,
  output logic [8:0]              o_edge_rate_vus,
  output logic [6:0]              o_chop_period_us,
  output logic                    o_torque_from_adc,
  output logic                    o_predictive_en,
  output logic                    o_bridges_off,
  output logic                    o_step_pulse
);

  function automatic logic op_is(input logic [7:0] op, input logic [7:0] code,
                                 input logic [7:0] mask);
    op_is = ((op & mask) == code);
  endfunction

  // Pin inputs through the synchroniser
  logic [sst_pkg::SST_SYNC_W-1:0] pins_async;
  logic [sst_pkg::SST_SYNC_W-1:0] pins_sync;
  logic s_oc;
  logic s_hsd;
  logic s_hwr;
  logic s_uv;
  logic s_contact;
  logic s_busy;
  logic s_pulse;
  logic s_clkin;

  assign pins_async = {i_clock_in_pin, i_external_pulse_input, i_busy_pin,
                       i_limit_contact_input, i_undervoltage, i_heat_warning,
                       i_heat_shutdown, i_overcurrent};
  assign {s_clkin, s_pulse, s_busy, s_contact, s_uv, s_hwr, s_hsd, s_oc} = pins_sync;

  sst_sync2 #(
    .WIDTH (sst_pkg::SST_SYNC_W)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (pins_async),
    .o_sync    (pins_sync)
  );

  // State
  logic [7:0]  alarm_mask_r;
  logic [7:0]  alarm_mask_nxt;
  logic [15:0] setup_r;
  logic [15:0] setup_nxt;
  logic        lat_oc_r, lat_hsd_r, lat_hwr_r, lat_uv_r;
  logic        lat_oc_nxt, lat_hsd_nxt, lat_hwr_nxt, lat_uv_nxt;
  logic        lat_ref_r, lat_unk_r, lat_evt_r;
  logic        lat_ref_nxt, lat_unk_nxt, lat_evt_nxt;
  logic        floating_r, floating_nxt;
  logic        extp_r, extp_nxt;
  logic        dir_r, dir_nxt;
  logic        contact_prev_r, contact_prev_nxt;
  logic        pulse_prev_r, pulse_prev_nxt;
  sst_pkg::sst_motion_t motion_r, motion_nxt;
  logic        rd_valid_r, rd_valid_nxt;
  logic [15:0] rd_data_r, rd_data_nxt;
  logic [15:0] flags_r, flags_nxt;
  logic        alarm_oe_r, alarm_oe_nxt;
  logic        alarm_o_r;
  sst_pkg::sst_clock_t clk_r, clk_nxt;
  logic        clk_out_r, clk_out_nxt;
  logic [8:0]  slew_r, slew_nxt;
  logic [6:0]  chop_r, chop_nxt;
  logic        torque_r, torque_nxt;
  logic        pred_r, pred_nxt;
  logic        step_r, step_nxt;

  // Decode and next-state scratch
  logic [7:0]  op;
  logic [4:0]  op_addr;
  logic        addr_ok;
  logic        is_set, is_get, is_known, moving_cmd, leave_extp, dir_cmd;
  logic        contact_edge, err_force, flag_read;
  logic        set_ref, set_unk;
  logic [15:0] flag_word;
  logic [7:0]  alarm_cond;
  logic [2:0]  clk_choice;
  logic        pin_mode;

  always_comb begin
    op         = i_cmd_byte;
    op_addr    = i_cmd_byte[4:0];
    addr_ok    = (op_addr >= sst_pkg::SST_ADDR_MIN) && (op_addr <= sst_pkg::SST_ADDR_MAX);
    motion_nxt = '0;
    set_ref    = 1'b0;
    set_unk    = 1'b0;
    flag_read  = 1'b0;
    rd_valid_nxt = 1'b0;
    rd_data_nxt  = rd_data_r;
    alarm_mask_nxt = alarm_mask_r;
    setup_nxt      = setup_r;
    dir_nxt        = dir_r;
    extp_nxt       = extp_r;
    is_set = (op[7:5] == sst_pkg::SST_OP_SET) && (op != sst_pkg::SST_OP_NOP);
    is_get = (op[7:5] == sst_pkg::SST_OP_GET);
    motion_nxt.rate      = op_is(op, sst_pkg::SST_OP_RATE, sst_pkg::SST_MASK_D);
    motion_nxt.ext_pulse = op_is(op, sst_pkg::SST_OP_EXTP, sst_pkg::SST_MASK_D);
    motion_nxt.rel_step  = op_is(op, sst_pkg::SST_OP_STEP, sst_pkg::SST_MASK_D);
    motion_nxt.seek      = op_is(op, sst_pkg::SST_OP_SEEK, sst_pkg::SST_MASK_ALL);
    motion_nxt.seek_dir  = op_is(op, sst_pkg::SST_OP_SEEKD, sst_pkg::SST_MASK_D);
    motion_nxt.origin    = op_is(op, sst_pkg::SST_OP_HOME, sst_pkg::SST_MASK_ALL);
    motion_nxt.marker    = op_is(op, sst_pkg::SST_OP_MARK, sst_pkg::SST_MASK_ALL);
    motion_nxt.seek_contact = op_is(op, sst_pkg::SST_OP_SCON, sst_pkg::SST_MASK_AD);
    motion_nxt.back_off  = op_is(op, sst_pkg::SST_OP_BACK, sst_pkg::SST_MASK_AD);
    motion_nxt.ramp_halt = op_is(op, sst_pkg::SST_OP_RHALT, sst_pkg::SST_MASK_ALL);
    motion_nxt.imm_halt  = op_is(op, sst_pkg::SST_OP_IHALT, sst_pkg::SST_MASK_ALL);
    motion_nxt.float_ramp = op_is(op, sst_pkg::SST_OP_FRAMP, sst_pkg::SST_MASK_ALL);
    motion_nxt.float_now = op_is(op, sst_pkg::SST_OP_FNOW, sst_pkg::SST_MASK_ALL);
    motion_nxt.pos_clear = op_is(op, sst_pkg::SST_OP_PCLR, sst_pkg::SST_MASK_ALL);
    motion_nxt.reinit    = op_is(op, sst_pkg::SST_OP_INIT, sst_pkg::SST_MASK_ALL);
    motion_nxt.action    = op[sst_pkg::SST_OP_ACT];
    motion_nxt.dir       = op[0];
    is_known = (|motion_nxt[16:2]) || is_get
               || (op == sst_pkg::SST_OP_NOP) || (op == sst_pkg::SST_OP_FREAD)
               || (op == sst_pkg::SST_OP_RSV0) || (op == sst_pkg::SST_OP_RSV1);
    // Pulse mode and relative steps only while stopped
    if (i_motor_running && (motion_nxt.ext_pulse || motion_nxt.rel_step)) begin
      set_ref = i_cmd_valid;
      motion_nxt.ext_pulse = 1'b0;
      motion_nxt.rel_step  = 1'b0;
    end
    if (!i_cmd_valid) begin
      motion_nxt = '0;
    end else if (is_set || is_get) begin
      set_unk = !addr_ok;
      if (is_get && (op_addr == sst_pkg::SST_ADDR_ALARM)) begin
        rd_valid_nxt = 1'b1;
        rd_data_nxt  = {8'h00, alarm_mask_r};
      end else if (is_get && (op_addr == sst_pkg::SST_ADDR_SETUP)) begin
        rd_valid_nxt = 1'b1;
        rd_data_nxt  = setup_r;
      end else if (is_get && (op_addr == sst_pkg::SST_ADDR_FLAGS)) begin
        rd_valid_nxt = 1'b1;
        rd_data_nxt  = flags_r;
      end
    end else if (op == sst_pkg::SST_OP_FREAD) begin
      flag_read    = 1'b1;
      rd_valid_nxt = 1'b1;
      rd_data_nxt  = flags_r;
    end else if (!is_known) begin
      set_unk = 1'b1;
    end
    moving_cmd = motion_nxt.rate || motion_nxt.rel_step || motion_nxt.seek
                 || motion_nxt.seek_dir || motion_nxt.origin || motion_nxt.marker
                 || motion_nxt.seek_contact || motion_nxt.back_off
                 || motion_nxt.ramp_halt || motion_nxt.imm_halt;
    leave_extp = moving_cmd && !motion_nxt.ramp_halt && !motion_nxt.imm_halt;
    dir_cmd = motion_nxt.rate || motion_nxt.ext_pulse || motion_nxt.rel_step
              || motion_nxt.seek_dir || motion_nxt.seek_contact || motion_nxt.back_off;
    if (dir_cmd) begin
      dir_nxt = motion_nxt.dir;
    end
    if (motion_nxt.ext_pulse) begin
      extp_nxt = 1'b1;
    end else if (leave_extp) begin
      extp_nxt = 1'b0;
    end
    // Setting writes land at the end of their argument bytes
    if (i_set_wr) begin
      if (i_set_addr == sst_pkg::SST_ADDR_ALARM) begin
        alarm_mask_nxt = i_set_data[7:0];
      end else if (i_set_addr == sst_pkg::SST_ADDR_SETUP) begin
        if (i_motor_running) begin
          set_ref = 1'b1;
        end else begin
          setup_nxt = i_set_data;
        end
      end else if (i_set_addr == sst_pkg::SST_ADDR_FLAGS) begin
        set_ref = 1'b1;
      end
    end
    // Contact closure is the falling edge of the input
    contact_prev_nxt = s_contact;
    contact_edge = contact_prev_r && !s_contact;
    if (contact_edge && !setup_r[sst_pkg::SST_SU_CSTOP]) begin
      motion_nxt.imm_halt = 1'b1;
    end
    if (motion_nxt.reinit) begin
      alarm_mask_nxt = sst_pkg::SST_ALARM_RST;
      setup_nxt      = sst_pkg::SST_SETUP_RST;
      extp_nxt       = 1'b0;
    end
    // Latched flags: a new event in the clearing cycle wins
    lat_oc_nxt  = (lat_oc_r  && !flag_read) || s_oc;
    lat_hsd_nxt = (lat_hsd_r && !flag_read) || s_hsd;
    lat_hwr_nxt = (lat_hwr_r && !flag_read) || s_hwr;
    lat_uv_nxt  = (lat_uv_r  && !flag_read) || s_uv || motion_nxt.reinit;
    lat_ref_nxt = (lat_ref_r && !flag_read) || set_ref;
    lat_unk_nxt = (lat_unk_r && !flag_read) || set_unk;
    lat_evt_nxt = (lat_evt_r && !flag_read) || contact_edge;
    // Faults that hold the bridges floating
    err_force = (s_oc && setup_r[sst_pkg::SST_SU_OVERCURRENT_SHUTDOWN_EN]) || s_hsd || s_uv;
    if (motion_nxt.reinit || err_force || motion_nxt.float_ramp || motion_nxt.float_now) begin
      floating_nxt = 1'b1;
    end else if (moving_cmd) begin
      floating_nxt = 1'b0;
    end else begin
      floating_nxt = floating_r;
    end
    flag_word = '0;
    flag_word[sst_pkg::SST_FW_HIZ]   = floating_nxt;
    flag_word[sst_pkg::SST_FW_BUSY]  = s_busy;
    flag_word[sst_pkg::SST_FW_CLVL]  = !s_contact;
    flag_word[sst_pkg::SST_FW_CEVT]  = lat_evt_nxt;
    flag_word[sst_pkg::SST_FW_DIR]   = dir_nxt;
    flag_word[sst_pkg::SST_FW_PH_MSB:sst_pkg::SST_FW_PH_LSB] = i_motion_phase;
    flag_word[sst_pkg::SST_FW_REF]   = lat_ref_nxt;
    flag_word[sst_pkg::SST_FW_UNK]   = lat_unk_nxt;
    flag_word[sst_pkg::SST_FW_UV_N]  = !lat_uv_nxt;
    flag_word[sst_pkg::SST_FW_HWR_N] = !lat_hwr_nxt;
    flag_word[sst_pkg::SST_FW_HSD_N] = !lat_hsd_nxt;
    flag_word[sst_pkg::SST_FW_OC_N]  = !lat_oc_nxt;
    flag_word[sst_pkg::SST_FW_EXTP]  = extp_nxt;
    flags_nxt = flag_word;
    // Alarm pin
    alarm_cond = '0;
    alarm_cond[sst_pkg::SST_AL_OC]  = lat_oc_nxt;
    alarm_cond[sst_pkg::SST_AL_HSD] = lat_hsd_nxt;
    alarm_cond[sst_pkg::SST_AL_HWR] = lat_hwr_nxt;
    alarm_cond[sst_pkg::SST_AL_UV]  = lat_uv_nxt;
    alarm_cond[sst_pkg::SST_AL_CMD] = lat_ref_nxt || lat_unk_nxt;
    alarm_oe_nxt = |(alarm_cond & alarm_mask_nxt & sst_pkg::SST_AL_USED);
    // Clock source decode
    clk_choice = setup_r[sst_pkg::SST_SU_CLK_MSB:sst_pkg::SST_SU_CLK_LSB];
    pin_mode   = setup_r[sst_pkg::SST_SU_PIN_MODE];
    clk_nxt.int_osc    = !clk_choice[2];
    clk_nxt.xtal_drive = clk_choice[2] && !pin_mode;
    clk_nxt.ext_in     = clk_choice[2] && pin_mode;
    clk_nxt.out_en     = pin_mode;
    clk_nxt.out_sel    = clk_choice[1:0];
    clk_nxt.freq_sel   = clk_choice[1:0];
    clk_out_nxt = clk_nxt.ext_in && !s_clkin;
    case (setup_r[sst_pkg::SST_SU_EDGE_MSB:sst_pkg::SST_SU_EDGE_LSB])
      2'h0: slew_nxt = sst_pkg::SST_SLEW_0;
      2'h1: slew_nxt = sst_pkg::SST_SLEW_1;
      2'h2: slew_nxt = sst_pkg::SST_SLEW_2;
      2'h3: slew_nxt = sst_pkg::SST_SLEW_3;
      default: slew_nxt = sst_pkg::SST_SLEW_0;
    endcase
    if (setup_r[sst_pkg::SST_SU_CHOP_MSB:sst_pkg::SST_SU_CHOP_LSB] < sst_pkg::SST_CHOP_MIN_CODE) begin
      chop_nxt = sst_pkg::SST_CHOP_STEP_US;
    end else begin
      chop_nxt = 7'(7'(setup_r[sst_pkg::SST_SU_CHOP_MSB:sst_pkg::SST_SU_CHOP_LSB])
                    * sst_pkg::SST_CHOP_STEP_US);
    end
    torque_nxt = setup_r[sst_pkg::SST_SU_TORQUE];
    pred_nxt   = setup_r[sst_pkg::SST_SU_PRED];
    // Step pulses from the external input in pulse mode only
    pulse_prev_nxt = s_pulse;
    step_nxt = extp_r && s_pulse && !pulse_prev_r;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      alarm_mask_r   <= sst_pkg::SST_ALARM_RST;
      setup_r        <= sst_pkg::SST_SETUP_RST;
      lat_oc_r       <= 1'b0;
      lat_hsd_r      <= 1'b0;
      lat_hwr_r      <= 1'b0;
      lat_uv_r       <= 1'b1;
      lat_ref_r      <= 1'b0;
      lat_unk_r      <= 1'b0;
      lat_evt_r      <= 1'b0;
      floating_r     <= 1'b1;
      extp_r         <= 1'b0;
      dir_r          <= 1'b1;
      contact_prev_r <= 1'b0;
      pulse_prev_r   <= 1'b0;
      motion_r       <= '0;
      rd_valid_r     <= 1'b0;
      rd_data_r      <= '0;
      flags_r        <= '0;
      alarm_oe_r     <= 1'b0;
      alarm_o_r      <= 1'b0;
      clk_r          <= '0;
      clk_out_r      <= 1'b0;
      slew_r         <= sst_pkg::SST_SLEW_0;
      chop_r         <= sst_pkg::SST_CHOP_STEP_US;
      torque_r       <= 1'b0;
      pred_r         <= 1'b0;
      step_r         <= 1'b0;
    end else begin
      alarm_mask_r   <= alarm_mask_nxt;
      setup_r        <= setup_nxt;
      lat_oc_r       <= lat_oc_nxt;
      lat_hsd_r      <= lat_hsd_nxt;
      lat_hwr_r      <= lat_hwr_nxt;
      lat_uv_r       <= lat_uv_nxt;
      lat_ref_r      <= lat_ref_nxt;
      lat_unk_r      <= lat_unk_nxt;
      lat_evt_r      <= lat_evt_nxt;
      floating_r     <= floating_nxt;
      extp_r         <= extp_nxt;
      dir_r          <= dir_nxt;
      contact_prev_r <= contact_prev_nxt;
      pulse_prev_r   <= pulse_prev_nxt;
      motion_r       <= motion_nxt;
      rd_valid_r     <= rd_valid_nxt;
      rd_data_r      <= rd_data_nxt;
      flags_r        <= flags_nxt;
      alarm_oe_r     <= alarm_oe_nxt;
      alarm_o_r      <= 1'b0;
      clk_r          <= clk_nxt;
      clk_out_r      <= clk_out_nxt;
      slew_r         <= slew_nxt;
      chop_r         <= chop_nxt;
      torque_r       <= torque_nxt;
      pred_r         <= pred_nxt;
      step_r         <= step_nxt;
    end
  end

  assign o_motion_req      = motion_r;
  assign o_read_valid      = rd_valid_r;
  assign o_read_data       = rd_data_r;
  assign o_flag_word       = flags_r;
  assign o_alarm_pin_o     = alarm_o_r;
  assign o_alarm_pin_oe    = alarm_oe_r;
  assign o_clock_cfg       = clk_r;
  assign o_clock_out_pin   = clk_out_r;
  assign o_edge_rate_vus   = slew_r;
  assign o_chop_period_us  = chop_r;
  assign o_torque_from_adc = torque_r;
  assign o_predictive_en   = pred_r;
  assign o_bridges_off     = floating_r;
  assign o_step_pulse      = step_r;
endmodule
`default_nettype wire

//--- dv/sst_pulse_src.sv
// Far-side pulse source feeding the external step pulse input
`timescale 1ns/1ps
`default_nettype none
module sst_pulse_src (
  input  wire logic i_en,
  output logic      o_pulse
);
  // 80 ns period while enabled, held low otherwise
  initial begin
    o_pulse = 1'b0;
    forever #40 o_pulse <= i_en & ~o_pulse;
  end
endmodule
`default_nettype wire

//--- dv/sst_chk.sv
// Port assertions of the stepper status and command block
`timescale 1ns/1ps
`default_nettype none
module sst_chk (
  input wire logic                 i_ref_clk,
  input wire logic                 i_rst_n,
  input wire logic                 i_cmd_valid,
  input wire logic [7:0]           i_cmd_byte,
  input wire logic                 i_set_wr,
  input wire logic [4:0]           i_set_addr,
  input wire logic [15:0]          i_set_data,
  input wire logic                 i_motor_running,
  input wire sst_pkg::sst_motion_t o_motion_req,
  input wire logic                 o_read_valid,
  input wire logic [15:0]          o_flag_word,
  input wire logic                 o_alarm_pin_o,
  input wire logic [8:0]           o_edge_rate_vus
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  a_alarm_drive_low: assert property (o_alarm_pin_o == 1'b0)
    else $error("alarm pin data not low");
  a_spare_bits_zero: assert property (o_flag_word[14:13] == 2'h0)
    else $error("flag bits 14:13 not zero");
  a_rate_cmd_pulse: assert property (i_cmd_valid && i_cmd_byte == 8'h51
    |=> o_motion_req.rate && o_motion_req.dir) else $error("rate pulse missing");
  a_flag_read_answer: assert property (i_cmd_valid && i_cmd_byte == 8'hd0
    |=> o_read_valid) else $error("flag read answer missing");
  a_nop_stays_silent: assert property (i_cmd_valid && i_cmd_byte == 8'h00
    |=> o_motion_req == '0 && !o_read_valid) else $error("nop produced output");
  a_unknown_sets_flag: assert property (i_cmd_valid && i_cmd_byte == 8'hff
    |=> o_flag_word[8]) else $error("unknown flag not set");
  a_flag_write_refused: assert property (i_set_wr && i_set_addr == 5'h19
    |=> o_flag_word[7]) else $error("flag word write not refused");
  a_running_setup_refused: assert property (i_set_wr && i_set_addr == 5'h18
    && i_motor_running |=> o_flag_word[7]) else $error("running setup write not refused");
  a_edge_rate_code1: assert property (i_set_wr && i_set_addr == 5'h18 && !i_motor_running
    && i_set_data[9:8] == 2'h1 |=> ##1 o_edge_rate_vus == 9'h04b) else $error("slew wrong");
endmodule
bind sst_stepper_status_command_decode sst_chk sst_chk_inst (.*);
`default_nettype wire

//--- dv/sst_stepper_status_command_decode_tb_top.sv
// Command-level bench of the stepper status and command block
`timescale 1ns/1ps
`default_nettype none
module sst_stepper_status_command_decode_tb_top;
  logic i_ref_clk = 0, i_rst_n = 0, i_cmd_valid = 0, i_set_wr = 0, i_motor_running = 0;
  logic [7:0] i_cmd_byte = 0;
  logic [4:0] i_set_addr = 0;
  logic [15:0] i_set_data = 0, o_read_data, o_flag_word;
  logic [1:0] i_motion_phase = 0;
  logic i_overcurrent = 0, i_heat_shutdown = 0, i_heat_warning = 0, i_undervoltage = 0;
  logic i_limit_contact_input = 1, i_busy_pin = 1, i_clock_in_pin = 0, pen = 0;
  logic i_external_pulse_input, o_read_valid, o_alarm_pin_o, o_alarm_pin_oe, o_clock_out_pin;
  logic o_torque_from_adc, o_predictive_en, o_bridges_off, o_step_pulse;
  logic [8:0] o_edge_rate_vus;
  logic [6:0] o_chop_period_us;
  sst_pkg::sst_motion_t o_motion_req;
  sst_pkg::sst_clock_t o_clock_cfg;
  int fails = 0, checked = 0, n = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  sst_stepper_status_command_decode sst_stepper_status_command_decode_inst (.*);
  sst_pulse_src sst_pulse_src_inst (.i_en(pen), .o_pulse(i_external_pulse_input));
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cmd(input logic [7:0] b);
    @(negedge i_ref_clk); i_cmd_valid = 1; i_cmd_byte = b;
    @(negedge i_ref_clk); i_cmd_valid = 0;
  endtask
  task setw(input logic [4:0] a, input logic [15:0] d);
    @(negedge i_ref_clk); i_set_wr = 1; i_set_addr = a; i_set_data = d;
    @(negedge i_ref_clk); i_set_wr = 0;
  endtask
  task end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #50000; fails++; end_of_test;
  end
  initial begin
    repeat (2) @(negedge i_ref_clk); i_rst_n = 1;
    repeat (4) @(negedge i_ref_clk);
    cmd(8'hd0); chk("reset flags", {o_read_data[9], o_read_data[0]}, 16'h1);
    @(negedge i_ref_clk); chk("oe clear", o_alarm_pin_oe, 16'h0);
    cmd(8'hff); @(negedge i_ref_clk); chk("oe cmd", o_alarm_pin_oe, 16'h1);
    setw(5'h17, 16'h0030); cmd(8'hd0); cmd(8'hff); @(negedge i_ref_clk);
    chk("oe unused", o_alarm_pin_oe, 16'h0);
    $display("test alarm done");
    setw(5'h18, 16'hfd3d); @(negedge i_ref_clk);
    chk("slew", o_edge_rate_vus, 16'h004b);
    chk("chop", o_chop_period_us, 16'h007c);
    chk("clock cfg", o_clock_cfg, 16'h0035);
    chk("clock out", o_clock_out_pin, 16'h1);
    chk("torque src", o_torque_from_adc, 16'h1);
    chk("predictive", o_predictive_en, 16'h1);
    cmd(8'h38); chk("setup read", o_read_data, 16'hfd3d);
    setw(5'h19, 16'hffff); chk("flag write", o_flag_word[7], 16'h1);
    $display("test setup done");
    cmd(8'hd0); cmd(8'h00); chk("nop", 16'(|o_motion_req), 16'h0);
    i_motor_running = 1; setw(5'h18, 16'h0000);
    chk("refused setup", o_flag_word[7], 16'h1);
    cmd(8'hd0); cmd(8'h40);
    chk("refused step", 16'(|o_motion_req), 16'h0);
    chk("refused flag", o_flag_word[7], 16'h1);
    cmd(8'h38); chk("setup kept", o_read_data, 16'hfd3d);
    i_motor_running = 0; cmd(8'h51); chk("rate", o_motion_req.rate, 16'h1);
    chk("leave float", o_bridges_off, 16'h0);
    $display("test commands done");
    pen = 1; cmd(8'h58); chk("pulse mode", o_flag_word[15], 16'h1);
    repeat (40) @(negedge i_ref_clk) n += o_step_pulse;
    chk("steps", 16'(n), 16'h5);
    i_overcurrent = 1; i_clock_in_pin = 1; i_limit_contact_input = 0;
    repeat (4) @(negedge i_ref_clk);
    chk("oc flag", o_flag_word[12], 16'h0);
    chk("oc bridges", o_bridges_off, 16'h0);
    chk("clock inv", o_clock_out_pin, 16'h0);
    chk("contact", o_flag_word[3:2], 16'h3);
    $display("test pins done");
    cmd(8'hc0); cmd(8'hd0);
    chk("reinit flags", {o_read_data[9], o_read_data[0]}, 16'h1);
    chk("oe reinit", o_alarm_pin_oe, 16'h1);
    $display("test reinit done");
    end_of_test;
  end
endmodule
`default_nettype wire
